// ### tdm_pkg.sv
// Shared constants and types for the four-slot multiplexed audio output link
// Operation
// - Three link signals: bit clock, frame sync, data
// - Three speed ranges up to 216 kHz
// - Master bit clock is 256 times frame rate
// - Master frame sync high 128 bit clocks
// - External master nominally supplies 256x bit clock
// - Slave accepts any bit-to-frame clock ratio
// - Slave frame sync width 1 to 244
// - Frame sync valid before rising bit edge
// - Data stable around rising edge, captured there
// - Bit clock phases derived from master clock
// - Divider select gives one-third high duty
// - Frame sync rise starts four 32-bit slots
// - Master drives both clocks, slave takes them
package tam_pkg;
	// ==========================================
	// Frame layout
	localparam int SLOT_BITS     = 32;
	localparam int NUM_SLOTS     = 4;
	localparam int WORD_BITS     = 24;
	localparam int FRAME_BITS    = 256;
	localparam int SYNC_HIGH     = 128;
	localparam int SYNC_MIN      = 1;
	localparam int SYNC_MAX      = 244;
	// ==========================================
	// Speed ranges, frame rate in kHz
	localparam int SINGLE_MIN_KHZ = 2;
	localparam int DOUBLE_MIN_KHZ = 54;
	localparam int QUAD_MIN_KHZ   = 108;
	localparam int QUAD_MAX_KHZ   = 216;
	// ==========================================
	// Bit clock divider, in ref_clk cycles
	localparam int HALF_DIV      = 2;
	localparam int THIRD_DIV     = 3;
	localparam int THIRD_HIGH    = 1;
	localparam int CNT_W         = 8;
	typedef enum logic [2:0] {
		SPD_SINGLE = 3'h1,
		SPD_DOUBLE = 3'h2,
		SPD_QUAD   = 3'h4
	} tam_speed_type;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_SLOTS = 3'h2,
		ST_TAIL  = 3'h4
	} tam_state_type;
	typedef logic [WORD_BITS-1:0] tam_word_type;
endpackage

// ### tam_link_if.sv
// Link interface joining the converter end and the receiving end
`timescale 1ns/1ps
interface tam_link_if;
	logic bclk_dev;
	logic bclk_dev_oe;
	logic sync_dev;
	logic sync_dev_oe;
	logic bclk_rx;
	logic bclk_rx_oe;
	logic sync_rx;
	logic sync_rx_oe;
	logic serial_data_out;
	// Resolved wire levels; whichever end enables drives
	logic bit_clock;
	logic frame_sync;
	assign bit_clock  = bclk_dev_oe ? bclk_dev : (bclk_rx_oe ? bclk_rx : 1'b0);
	assign frame_sync = sync_dev_oe ? sync_dev : (sync_rx_oe ? sync_rx : 1'b0);
	modport dev (output bclk_dev, bclk_dev_oe, sync_dev, sync_dev_oe, serial_data_out,
		input bit_clock, frame_sync);
	modport rx (output bclk_rx, bclk_rx_oe, sync_rx, sync_rx_oe,
		input bit_clock, frame_sync, serial_data_out);
endinterface

// ### tam_dev.sv
// Converter end: clock master or slave, shifts four slots per frame
`timescale 1ns/1ps
module tam_dev #(
	parameter int FRAME_LEN = 256
) (
	input  wire logic                     ref_clk,
	input  wire logic                     resetn,
	tam_link_if.dev                       link,
	input  wire logic                     master_mode,
	input  wire logic                     third_duty_divider_select,
	input  wire tam_pkg::tam_word_type    sample_word [tam_pkg::NUM_SLOTS],
	output logic                          sample_take,
	output logic                          frame_start
);
	import tam_pkg::*;

	logic [CNT_W-1:0] div_r;
	logic             bclk_r;
	logic [8:0]       bit_cnt_r;
	logic             sync_r;
	logic             bclk_d_r;
	logic             fsync_d_r;
	logic             data_r;
	logic             sync_oe_r;
	tam_word_type     shadow_r [NUM_SLOTS];
	tam_state_type    state_r;
	logic             bit_rise;
	logic             new_frame;
	logic [CNT_W-1:0] div_top;

	// ==========================================
	// Bit clock generation from ref_clk
	// Phases are whole ref_clk cycles, so duty is set by the divider, not by the reference duty
	assign div_top = third_duty_divider_select ? CNT_W'(THIRD_DIV - 1) : CNT_W'(HALF_DIV - 1);

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			div_r  <= '0;
			bclk_r <= 1'b0;
		end else if (master_mode) begin
			div_r  <= (div_r >= div_top) ? '0 : div_r + 1'b1;
			if (third_duty_divider_select)
				bclk_r <= (div_r == div_top);
			else
				bclk_r <= (div_r == '0);
		end else begin
			div_r  <= '0;
			bclk_r <= 1'b0;
		end
	end

	// ==========================================
	// Master frame sync: 256 bits per frame, 128 high
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			bit_cnt_r <= 9'(FRAME_LEN - 1);
			sync_r    <= 1'b0;
		end else if (master_mode && bit_rise) begin
			// Rise is seen one cycle late, which is the fall of our own clock
			// Starting at the last count makes the first sync full width
			bit_cnt_r <= (bit_cnt_r == 9'(FRAME_LEN - 1)) ? '0 : bit_cnt_r + 1'b1;
			sync_r    <= (bit_cnt_r == 9'(FRAME_LEN - 1)) || (bit_cnt_r < 9'(SYNC_HIGH - 1));
		end else if (!master_mode) begin
			bit_cnt_r <= 9'(FRAME_LEN - 1);
			sync_r    <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			sync_oe_r <= 1'b0;
		else
			sync_oe_r <= master_mode;
	end

	assign link.bclk_dev    = bclk_r;
	assign link.bclk_dev_oe = sync_oe_r;
	assign link.sync_dev    = sync_r;
	assign link.sync_dev_oe = sync_oe_r;

	// ==========================================
	// Edge detection on the resolved link clock
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			bclk_d_r  <= 1'b0;
			fsync_d_r <= 1'b0;
		end else begin
			bclk_d_r <= link.bit_clock;
			if (bit_rise)
				fsync_d_r <= link.frame_sync;
		end
	end

	assign bit_rise  = link.bit_clock && !bclk_d_r;
	// Any sync width and ratio works: only the rising edge matters
	assign new_frame = bit_rise && link.frame_sync && !fsync_d_r;

	// ==========================================
	// Slot shifter, new bit launched after each rising edge
	logic [7:0] pos_r;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_r     <= ST_IDLE;
			pos_r       <= '0;
			data_r      <= 1'b0;
			sample_take <= 1'b0;
			frame_start <= 1'b0;
			for (int i = 0; i < NUM_SLOTS; i++)
				shadow_r[i] <= '0;
		end else begin
			sample_take <= 1'b0;
			frame_start <= 1'b0;
			if (new_frame) begin
				// Capture all four words at once so a frame is coherent
				for (int i = 0; i < NUM_SLOTS; i++)
					shadow_r[i] <= sample_word[i];
				sample_take <= 1'b1;
				frame_start <= 1'b1;
				state_r     <= ST_SLOTS;
				pos_r       <= 8'h01;
				data_r      <= sample_word[0][WORD_BITS-1];
			end else if (bit_rise) begin
				// Change one cycle after the rise keeps data stable around it
				unique case (state_r)
					ST_IDLE: begin
						data_r <= 1'b0;
					end
					ST_SLOTS: begin
						if (pos_r[4:0] < 5'(WORD_BITS))
							data_r <= shadow_r[pos_r[6:5]][5'(WORD_BITS - 1) - pos_r[4:0]];
						else
							data_r <= 1'b0;
						if (pos_r == 8'(NUM_SLOTS * SLOT_BITS - 1))
							state_r <= ST_TAIL;
						pos_r <= pos_r + 1'b1;
					end
					ST_TAIL: begin
						data_r <= 1'b0;
					end
				endcase
			end
		end
	end

	assign link.serial_data_out = data_r;
endmodule

// ### tam_rx.sv
// Receiving end: optional clock source, captures four slots on rising edges
`timescale 1ns/1ps
module tam_rx #(
	parameter int FRAME_LEN = 256,
	parameter int SYNC_LEN  = 128
) (
	input  wire logic                     ref_clk,
	input  wire logic                     resetn,
	tam_link_if.rx                        link,
	input  wire logic                     drive_clocks,
	output tam_pkg::tam_word_type         rx_word [tam_pkg::NUM_SLOTS],
	output logic                          rx_valid
);
	import tam_pkg::*;

	logic       bclk_r;
	logic       oe_r;
	logic       sync_r;
	logic [8:0] gen_cnt_r;
	logic       bclk_d_r;
	logic       fsync_d_r;
	logic [7:0] pos_r;
	logic       active_r;
	tam_word_type sh_r [NUM_SLOTS];
	logic       bit_rise;

	// ==========================================
	// Optional clock source for a slave converter
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			bclk_r    <= 1'b0;
			sync_r    <= 1'b0;
			gen_cnt_r <= '0;
			oe_r      <= 1'b0;
		end else begin
			oe_r   <= drive_clocks;
			bclk_r <= drive_clocks ? !bclk_r : 1'b0;
			if (drive_clocks && bclk_r) begin
				// Sync updated on the falling edge, ahead of the rise
				gen_cnt_r <= (gen_cnt_r == 9'(FRAME_LEN - 1)) ? '0 : gen_cnt_r + 1'b1;
				sync_r <= (gen_cnt_r == 9'(FRAME_LEN - 1)) || (gen_cnt_r < 9'(SYNC_LEN - 1));
			end
		end
	end

	assign link.bclk_rx    = bclk_r;
	assign link.bclk_rx_oe = oe_r;
	assign link.sync_rx    = sync_r;
	assign link.sync_rx_oe = oe_r;

	// ==========================================
	// Capture on rising bit clock edge
	assign bit_rise = link.bit_clock && !bclk_d_r;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			bclk_d_r  <= 1'b0;
			fsync_d_r <= 1'b0;
			pos_r     <= '0;
			active_r  <= 1'b0;
			rx_valid  <= 1'b0;
			for (int i = 0; i < NUM_SLOTS; i++) begin
				sh_r[i]    <= '0;
				rx_word[i] <= '0;
			end
		end else begin
			bclk_d_r <= link.bit_clock;
			rx_valid <= 1'b0;
			if (bit_rise) begin
				fsync_d_r <= link.frame_sync;
				if (link.frame_sync && !fsync_d_r) begin
					// First bit is launched just after this edge, taken at the next
					pos_r    <= 8'h00;
					active_r <= 1'b1;
				end else if (active_r) begin
					if (pos_r[4:0] < 5'(WORD_BITS))
						sh_r[pos_r[6:5]] <= {sh_r[pos_r[6:5]][WORD_BITS-2:0], link.serial_data_out};
					if (pos_r == 8'(NUM_SLOTS * SLOT_BITS - 1)) begin
						active_r <= 1'b0;
						rx_valid <= 1'b1;
						for (int i = 0; i < NUM_SLOTS; i++)
							rx_word[i] <= sh_r[i];
					end
					pos_r <= pos_r + 1'b1;
				end
			end
		end
	end
endmodule

// ### tam_link_monitor.sv
// Concurrent checks on the link between the converter end and the receiving end
`timescale 1ns/1ps
module tam_link_monitor (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic bclk_dev,
	input wire logic bclk_dev_oe,
	input wire logic sync_dev,
	input wire logic sync_dev_oe,
	input wire logic bclk_rx_oe,
	input wire logic sync_rx_oe,
	input wire logic serial_data_out
);
	import tam_pkg::*;
	logic [8:0] fcnt_r;
	logic [8:0] hcnt_r;
	logic       seen_r;
	logic       bd_r;
	logic       sd_r;
	wire        brise = bclk_dev && !bd_r && bclk_dev_oe;
	// ==========================================
	// Bit clock rises per frame and while sync is high
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			{fcnt_r, hcnt_r, seen_r, bd_r, sd_r} <= '0;
		end else begin
			bd_r <= bclk_dev;
			sd_r <= sync_dev;
			if (sync_dev && !sd_r) begin
				fcnt_r <= '0;
				hcnt_r <= '0;
				seen_r <= sync_dev_oe;
			end else begin
				if (brise) fcnt_r <= fcnt_r + 9'h1;
				if (brise && sync_dev) hcnt_r <= hcnt_r + 9'h1;
			end
		end
	end
	// ==========================================
	// Assertions
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	a_bclk_one_driver: assert property (!(bclk_dev_oe && bclk_rx_oe))
		else $error("both ends drive the bit clock");
	a_sync_one_driver: assert property (!(sync_dev_oe && sync_rx_oe))
		else $error("both ends drive the frame sync");
	a_bclk_high_one: assert property (brise |=> !bclk_dev)
		else $error("bit clock high longer than one cycle");
	a_bclk_low_bound: assert property (bclk_dev_oe && $fell(bclk_dev) |-> ##[1:2] bclk_dev)
		else $error("bit clock low phase too long");
	a_sync_at_fall: assert property (sync_dev_oe && $rose(sync_dev) |-> $fell(bclk_dev))
		else $error("frame sync rose off a falling bit clock");
	a_sync_width: assert property (sync_dev_oe && $fell(sync_dev) |-> hcnt_r == SYNC_HIGH)
		else $error("frame sync width wrong");
	a_frame_len: assert property (seen_r && sync_dev_oe && $rose(sync_dev) |-> fcnt_r == FRAME_BITS)
		else $error("frame length wrong");
	a_data_hold: assert property (brise |-> $stable(serial_data_out))
		else $error("data changed at a rising bit clock");
	a_tail_zero: assert property (brise && fcnt_r inside {[130:250]} |-> !serial_data_out)
		else $error("tail bit not zero");
	a_pad_zero: assert property (brise && fcnt_r < 128 && fcnt_r[4:0] inside {[26:29]} |-> !serial_data_out)
		else $error("slot pad bit not zero");
endmodule

// ### testbench.sv
// Self-checking bench joining both link ends across the link interface
`timescale 1ns/1ps
module testbench;
	import tam_pkg::*;
	logic         ref_clk;
	logic         resetn;
	logic         master_mode;
	logic         third_sel;
	logic         drive_clocks;
	logic         sample_take;
	logic         frame_start;
	logic         rx_valid;
	tam_word_type sample_word [NUM_SLOTS];
	tam_word_type rx_word [NUM_SLOTS];
	tam_word_type exp_r [NUM_SLOTS];
	tam_word_type corner_w [NUM_SLOTS] = '{24'hffffff, 24'h800000, 24'h000001, 24'h000000};
	logic         bclk_q;
	logic         fs_q;
	logic         exp_start_r;
	int           n_mismatch;
	int           compares;
	tam_link_if lnk();
	tam_dev i_tam_dev (.ref_clk(ref_clk), .resetn(resetn), .link(lnk), .master_mode(master_mode),
		.third_duty_divider_select(third_sel), .sample_word(sample_word), .sample_take(sample_take),
		.frame_start(frame_start));
	// Shortest legal sync exercised whenever the receiver drives the clocks
	tam_rx #(.SYNC_LEN(1)) i_tam_rx (.ref_clk(ref_clk), .resetn(resetn), .link(lnk),
		.drive_clocks(drive_clocks), .rx_word(rx_word), .rx_valid(rx_valid));
	tam_link_monitor i_tam_link_monitor (.ref_clk(ref_clk), .resetn(resetn), .bclk_dev(lnk.bclk_dev),
		.bclk_dev_oe(lnk.bclk_dev_oe), .sync_dev(lnk.sync_dev), .sync_dev_oe(lnk.sync_dev_oe),
		.bclk_rx_oe(lnk.bclk_rx_oe), .sync_rx_oe(lnk.sync_rx_oe), .serial_data_out(lnk.serial_data_out));
	// ==========================================
	// Clock and helpers
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	function automatic tam_word_type expect_word(input int i);
		return exp_r[i] & 24'hffffff;
	endfunction
	task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic finish_test();
		$display("Mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic wait_valid();
		int n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (rx_valid !== 1'b1 && n < 3000);
		check("rx_valid", 24'h1, {23'h0, rx_valid});
	endtask
	// First frame may carry the old words, so the second is compared
	task automatic frame_set(input bit corner);
		for (int i = 0; i < NUM_SLOTS; i++) begin
			exp_r[i] = corner ? corner_w[i] : tam_word_type'($urandom);
			sample_word[i] <= exp_r[i];
		end
		wait_valid();
		wait_valid();
		for (int i = 0; i < NUM_SLOTS; i++) check("rx_word", expect_word(i), rx_word[i]);
	endtask
	task automatic apply(input logic m, input logic t, input logic d);
		resetn       <= 1'b0;
		master_mode  <= m;
		third_sel    <= t;
		drive_clocks <= d;
		repeat (10) @(posedge ref_clk);
		resetn <= 1'b1;
		frame_set(1'b1);
		check("bclk owner", {23'h0, m}, {23'h0, lnk.bclk_dev_oe});
		repeat (2) frame_set(1'b0);
	endtask
	// Frame start expected one cycle after a sync rise seen at a bit clock rise
	always @(posedge ref_clk) begin
		if (!resetn) begin
			bclk_q      <= 1'b0;
			fs_q        <= 1'b0;
			exp_start_r <= 1'b0;
		end else begin
			compares++;
			if (frame_start !== exp_start_r || sample_take !== exp_start_r) begin
				n_mismatch++;
				$display("[FAIL] frame_start expected %b seen %b take %b", exp_start_r, frame_start, sample_take);
			end
			bclk_q      <= lnk.bit_clock;
			exp_start_r <= lnk.bit_clock && !bclk_q && lnk.frame_sync && !fs_q;
			if (lnk.bit_clock && !bclk_q)
				fs_q <= lnk.frame_sync;
		end
	end
	// ==========================================
	// Main sequence and watchdog
	initial begin
		{resetn, master_mode, third_sel, drive_clocks} = 4'h0;
		for (int i = 0; i < NUM_SLOTS; i++) sample_word[i] = 24'h0;
		n_mismatch = 0;
		compares = 0;
		void'($urandom(94583));
		apply(1'b1, 1'b0, 1'b0);
		apply(1'b1, 1'b1, 1'b0);
		apply(1'b0, 1'b0, 1'b1);
		finish_test();
	end
	initial begin
		repeat (60000) @(posedge ref_clk);
		n_mismatch++;
		$display("[FAIL] run expected done seen hang");
		finish_test();
	end
endmodule
